//--- shared/ccr_consts.svh
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH
// Attribute-space byte addresses
`define CCR_ADDR_OPTION 11'h200
`define CCR_ADDR_STATUS 11'h202
`define CCR_ADDR_PINREP 11'h204
`define CCR_ADDR_COPY 11'h206
// Reset values
`define CCR_RST_OPTION 8'h00
`define CCR_RST_STATUS 8'h00
`define CCR_RST_PINREP 8'h0C
`define CCR_RST_COPY 8'h00
// Option register fields
`define CCR_OPT_SOFT_RESET_BIT 7
`define CCR_OPT_LEVEL 6
// Status register fields
`define CCR_STS_CHANGED 7
`define CCR_STS_SIGEN 6
`define CCR_STS_IO8 5
`define CCR_STS_PWD 2
`define CCR_STS_INTERRUPT_PENDING 1
// Pin replacement fields
`define CCR_PIN_CHANGE 5
`define CCR_PIN_READY 1
`define CCR_PIN_FIXED 8'h0C
// Copy register field
`define CCR_COPY_BIT 4
// Mode select codes
`define CCR_MODE_MEM 6'h00
`define CCR_MODE_CONTIG 6'h01
`define CCR_MODE_PRIMARY 6'h02
`define CCR_MODE_SECONDARY 6'h03
// Cycles for a power-state transition to settle
`define CCR_PWR_SETTLE_CYC 4'h8
`endif

//--- shared/ccr_pkg.sv
package ccr_pkg;
    typedef enum logic [1:0] {
        MAP_MEMORY,
        MAP_CONTIG_IO,
        MAP_PRIMARY_IO,
        MAP_SECONDARY_IO
    } ccr_map_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_TO_SLEEP,
        PWR_SLEEP,
        PWR_TO_ACTIVE
    } ccr_pwr_t;

    typedef struct packed {
        logic reg_sel_n;
        logic ce1_n;
        logic oe_n;
        logic we_n;
        logic [10:0] addr;
        logic [7:0] wdata;
    } ccr_acc_t;
endpackage

//--- design/ccr_regs.sv
`timescale 1ns/1ns
`include "ccr_consts.svh"
// Overview of operation
// R1 - Registers reachable only outside true IDE mode
// R2 - Soft reset acts like hard reset, stays set
// R3 - Card reset clears configuration, starts initialisation
// R4 - Interrupt style bit selects pulse or level
// R5 - Mode field selects memory or I/O mapping
// R6 - Mode field zero after any reset
// R7 - Changed flag mirrors latch, drives status-change pin
// R8 - Status-change enable gates pin, else high
// R9 - Host sets eight-bit flag for narrow I/O
// R10 - Power-down bit selects sleep or active
// R11 - Ready reads busy until power state reached
// R12 - Card sleeps when idle, wakes on command
// R13 - Interrupt pending shows request, zero if disabled
// R14 - Ready change sets latch; host may write
// R15 - Ready bit reads pin, write sets mask
// R16 - Pin replacement resets to 0CH; the ready bit reads live, so it reads 0EH with the core ready
// R17 - Host writes copy before option register
// R18 - Copy number holds host-written value
// R19 - Host accesses registers with register select low
// R20 - Fixed bits ignore writes, read constant
module ccr_regs (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Host attribute access
    input wire ccr_pkg::ccr_acc_t HOST_ACC,
    input wire logic TRUE_IDE,
    // Card core status
    input wire logic CORE_READY,
    input wire logic CORE_IRQ,
    input wire logic IRQ_DISABLE,
    input wire logic CORE_IDLE,
    input wire logic CORE_CMD,
    // Read data pin
    output logic [7:0] RDATA,
    output logic RDATA_OE_N,
    // Status and configuration outputs
    output logic STATUS_CHANGE_PIN_N,
    output logic CARD_RESET,
    output logic LEVEL_IRQ,
    output ccr_pkg::ccr_map_t MAP_MODE,
    output logic EIGHT_BIT_IO,
    output logic CORE_SLEEP
);

    ////////////////////////////////////////////////////////////////////////
    // Access decode
    logic acc_sel;
    logic wr_stb;
    logic we_n_reg;
    logic we_n_next;

    always_comb begin
        acc_sel = !TRUE_IDE && !HOST_ACC.reg_sel_n && !HOST_ACC.ce1_n; // R1 R19
        we_n_next = HOST_ACC.we_n;
    end

    // Write taken on the falling edge of the write strobe
    // A strobe held low writes once; the host raises it between writes
    assign wr_stb = acc_sel && !HOST_ACC.we_n && we_n_reg;

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic soft_reset_bit_reg;
    logic soft_reset_bit_next;
    logic level_interrupt_select_reg;
    logic level_interrupt_select_next;
    logic [5:0] mode_select_reg;
    logic [5:0] mode_select_next;
    logic status_change_enable_reg;
    logic status_change_enable_next;
    logic eight_bit_io_only_reg;
    logic eight_bit_io_only_next;
    logic power_down_request_reg;
    logic power_down_request_next;
    logic ready_change_latch_reg;
    logic ready_change_latch_next;
    logic ready_mask_reg;
    logic ready_mask_next;
    logic copy_number_reg;
    logic copy_number_next;
    logic ready_seen_reg;
    logic ready_seen_next;
    logic [7:0] wd;
    logic ready_status;
    logic io_mode;

    assign wd = HOST_ACC.wdata;
    assign io_mode = (mode_select_reg != `CCR_MODE_MEM);

    always_comb begin
        soft_reset_bit_next = soft_reset_bit_reg;
        level_interrupt_select_next = level_interrupt_select_reg;
        mode_select_next = mode_select_reg;
        status_change_enable_next = status_change_enable_reg;
        eight_bit_io_only_next = eight_bit_io_only_reg;
        power_down_request_next = power_down_request_reg;
        ready_change_latch_next = ready_change_latch_reg;
        ready_mask_next = ready_mask_reg;
        copy_number_next = copy_number_reg;
        ready_seen_next = ready_status;
        // Only the defined bits of each write are stored, the rest read fixed
        if (wr_stb) begin
            unique case (HOST_ACC.addr)
                `CCR_ADDR_OPTION: begin
                    soft_reset_bit_next = wd[`CCR_OPT_SOFT_RESET_BIT]; // R2
                    level_interrupt_select_next = wd[`CCR_OPT_LEVEL]; // R4
                    mode_select_next = wd[5:0]; // R5
                end
                `CCR_ADDR_STATUS: begin
                    status_change_enable_next = wd[`CCR_STS_SIGEN]; // R8
                    eight_bit_io_only_next = wd[`CCR_STS_IO8]; // R9
                    power_down_request_next = wd[`CCR_STS_PWD]; // R10
                end
                `CCR_ADDR_PINREP: begin
                    ready_change_latch_next = wd[`CCR_PIN_CHANGE]; // R14
                    ready_mask_next = wd[`CCR_PIN_READY]; // R15
                end
                `CCR_ADDR_COPY: begin
                    copy_number_next = wd[`CCR_COPY_BIT]; // R18
                end
                default: begin
                end
            endcase
        end
        // Hardware set wins over a host clear in the same cycle
        if ((ready_status != ready_seen_reg) && !ready_mask_reg) begin
            ready_change_latch_next = 1'b1; // R14
        end
        // Soft reset clears everything else; the bit itself survives
        if (soft_reset_bit_reg) begin
            level_interrupt_select_next = 1'b0; // R2 R3
            mode_select_next = `CCR_MODE_MEM; // R6
            status_change_enable_next = 1'b0;
            eight_bit_io_only_next = 1'b0;
            power_down_request_next = 1'b0;
            ready_change_latch_next = 1'b0;
            ready_mask_next = 1'b0;
            copy_number_next = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            soft_reset_bit_reg <= 1'b0;
            level_interrupt_select_reg <= 1'b0;
            mode_select_reg <= `CCR_MODE_MEM; // R6
            status_change_enable_reg <= 1'b0;
            eight_bit_io_only_reg <= 1'b0;
            power_down_request_reg <= 1'b0;
            ready_change_latch_reg <= 1'b0;
            ready_mask_reg <= 1'b0;
            copy_number_reg <= 1'b0;
            // Idle level of ready, so leaving reset shows no false change
            ready_seen_reg <= 1'b1;
            we_n_reg <= 1'b1;
        end else begin
            soft_reset_bit_reg <= soft_reset_bit_next;
            level_interrupt_select_reg <= level_interrupt_select_next;
            mode_select_reg <= mode_select_next;
            status_change_enable_reg <= status_change_enable_next;
            eight_bit_io_only_reg <= eight_bit_io_only_next;
            power_down_request_reg <= power_down_request_next;
            ready_change_latch_reg <= ready_change_latch_next;
            ready_mask_reg <= ready_mask_next;
            copy_number_reg <= copy_number_next;
            ready_seen_reg <= ready_seen_next;
            we_n_reg <= we_n_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state
    ccr_pkg::ccr_pwr_t pwr_reg;
    ccr_pkg::ccr_pwr_t pwr_next;
    logic [3:0] settle_reg;
    logic [3:0] settle_next;
    logic want_sleep;

    // Sleeps on request or whenever the core is idle with no command
    assign want_sleep = power_down_request_reg || (CORE_IDLE && !CORE_CMD); // R10 R12

    // Settle count stands in for the time the core takes to change state
    always_comb begin
        pwr_next = pwr_reg;
        settle_next = settle_reg;
        unique case (pwr_reg)
            ccr_pkg::PWR_ACTIVE: begin
                if (want_sleep) begin
                    pwr_next = ccr_pkg::PWR_TO_SLEEP;
                    settle_next = `CCR_PWR_SETTLE_CYC;
                end
            end
            ccr_pkg::PWR_SLEEP: begin
                if (!want_sleep) begin
                    pwr_next = ccr_pkg::PWR_TO_ACTIVE; // R12
                    settle_next = `CCR_PWR_SETTLE_CYC;
                end
            end
            ccr_pkg::PWR_TO_SLEEP: begin
                settle_next = settle_reg - 4'h1;
                if (settle_reg == 4'h1) begin
                    pwr_next = ccr_pkg::PWR_SLEEP;
                end
            end
            ccr_pkg::PWR_TO_ACTIVE: begin
                settle_next = settle_reg - 4'h1;
                if (settle_reg == 4'h1) begin
                    pwr_next = ccr_pkg::PWR_ACTIVE;
                end
            end
        endcase
        // Request toggled mid-transition restarts toward the new target
        if (power_down_request_next != power_down_request_reg) begin
            pwr_next = power_down_request_next ? ccr_pkg::PWR_TO_SLEEP
                                               : ccr_pkg::PWR_TO_ACTIVE;
            settle_next = `CCR_PWR_SETTLE_CYC;
        end
        // Soft reset leaves the power state where a hard reset would
        if (soft_reset_bit_reg) begin
            pwr_next = ccr_pkg::PWR_ACTIVE; // R2
            settle_next = 4'h0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pwr_reg <= ccr_pkg::PWR_ACTIVE;
            settle_reg <= 4'h0;
        end else begin
            pwr_reg <= pwr_next;
            settle_reg <= settle_next;
        end
    end

    // Busy while a power transition is pending
    // A masked change still shows on the ready bit itself
    assign ready_status = CORE_READY && (pwr_reg != ccr_pkg::PWR_TO_SLEEP)
                          && (pwr_reg != ccr_pkg::PWR_TO_ACTIVE); // R11 R15

    ////////////////////////////////////////////////////////////////////////
    // Read words
    logic irq_pending;
    logic [7:0] option_rd;
    logic [7:0] status_rd;
    logic [7:0] pinrep_rd;
    logic [7:0] copy_rd;

    // Pending follows the core request; a disabled request reads zero
    assign irq_pending = CORE_IRQ && !IRQ_DISABLE; // R13

    // Fixed bits come from constants so host writes never reach them
    always_comb begin
        option_rd = {soft_reset_bit_reg, level_interrupt_select_reg, mode_select_reg};
        status_rd = 8'h00;
        status_rd[`CCR_STS_CHANGED] = ready_change_latch_reg; // R7
        status_rd[`CCR_STS_SIGEN] = status_change_enable_reg; // R8
        status_rd[`CCR_STS_IO8] = eight_bit_io_only_reg;
        status_rd[`CCR_STS_PWD] = power_down_request_reg; // R10
        status_rd[`CCR_STS_INTERRUPT_PENDING] = irq_pending; // R13
        pinrep_rd = `CCR_PIN_FIXED; // R16 R20
        pinrep_rd[`CCR_PIN_CHANGE] = ready_change_latch_reg; // R14
        pinrep_rd[`CCR_PIN_READY] = ready_status; // R15
        copy_rd = 8'h00; // R20
        copy_rd[`CCR_COPY_BIT] = copy_number_reg; // R18
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and outputs
    logic [7:0] rdata_next;
    logic rd_oe_n_next;
    logic status_pin_n_next;
    logic card_reset_next;
    logic level_irq_next;
    ccr_pkg::ccr_map_t map_mode_next;
    logic eight_bit_io_next;
    logic core_sleep_next;

    always_comb begin
        rdata_next = 8'h00;
        rd_oe_n_next = !(acc_sel && !HOST_ACC.oe_n && HOST_ACC.we_n);
        unique case (HOST_ACC.addr)
            `CCR_ADDR_OPTION: begin
                rdata_next = option_rd;
            end
            `CCR_ADDR_STATUS: begin
                rdata_next = status_rd;
            end
            `CCR_ADDR_PINREP: begin
                rdata_next = pinrep_rd;
            end
            `CCR_ADDR_COPY: begin
                rdata_next = copy_rd;
            end
            default: begin
                // Unmapped addresses leave the data lines released
                rd_oe_n_next = 1'b1;
            end
        endcase
    end

    always_comb begin
        // Pin sits high unless latch, enable and I/O mode all hold
        status_pin_n_next = !(ready_change_latch_reg && status_change_enable_reg
                              && io_mode); // R7 R8
        card_reset_next = soft_reset_bit_reg; // R2 R3
        level_irq_next = level_interrupt_select_reg; // R4
        // Codes above three keep only their low bits
        map_mode_next = ccr_pkg::ccr_map_t'(mode_select_reg[1:0]); // R5
        eight_bit_io_next = eight_bit_io_only_reg;
        core_sleep_next = (pwr_reg == ccr_pkg::PWR_SLEEP);
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 8'h00;
            RDATA_OE_N <= 1'b1;
            STATUS_CHANGE_PIN_N <= 1'b1;
            CARD_RESET <= 1'b1;
            LEVEL_IRQ <= 1'b0;
            MAP_MODE <= ccr_pkg::MAP_MEMORY;
            EIGHT_BIT_IO <= 1'b0;
            CORE_SLEEP <= 1'b0;
        end else begin
            RDATA <= rdata_next;
            RDATA_OE_N <= rd_oe_n_next;
            STATUS_CHANGE_PIN_N <= status_pin_n_next;
            CARD_RESET <= card_reset_next;
            LEVEL_IRQ <= level_irq_next;
            MAP_MODE <= map_mode_next;
            EIGHT_BIT_IO <= eight_bit_io_next;
            CORE_SLEEP <= core_sleep_next;
        end
    end

endmodule

//--- sim/ccr_regs_sva.sv
`timescale 1ns/1ns
module ccr_regs_sva (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Host side
    input wire ccr_pkg::ccr_acc_t HOST_ACC,
    input wire logic TRUE_IDE,
    // Watched outputs
    input wire logic [7:0] RDATA,
    input wire logic RDATA_OE_N,
    input wire logic STATUS_CHANGE_PIN_N,
    input wire logic CARD_RESET,
    input wire logic LEVEL_IRQ,
    input wire ccr_pkg::ccr_map_t MAP_MODE,
    input wire logic EIGHT_BIT_IO,
    input wire logic CORE_SLEEP
);
default clocking cb @(posedge CORE_CLK); endclocking
default disable iff (RST);
logic we_prev_reg;
logic take;
always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        we_prev_reg <= 1'b1;
    end else begin
        we_prev_reg <= HOST_ACC.we_n;
    end
end
// Write lands only on the falling strobe, never while held low
assign take = !TRUE_IDE && !HOST_ACC.reg_sel_n && !HOST_ACC.ce1_n && !HOST_ACC.we_n
    && we_prev_reg;
////////////////////////////////////////////////////////////
property p_ide; TRUE_IDE |=> RDATA_OE_N; endproperty
a_ide: assert property (p_ide) else $error("card drove data in ide mode");
property p_soft_reset_bit;
    take && HOST_ACC.addr == 11'h200 && HOST_ACC.wdata[7] |=> ##1 CARD_RESET [*2];
endproperty
a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset not held");
property p_level;
    take && HOST_ACC.addr == 11'h200 && !HOST_ACC.wdata[7]
    |=> ##1 LEVEL_IRQ == $past(HOST_ACC.wdata[6], 2);
endproperty
a_level: assert property (p_level) else $error("interrupt style wrong");
property p_mode;
    take && HOST_ACC.addr == 11'h200 && !HOST_ACC.wdata[7]
    |=> ##1 MAP_MODE == ccr_pkg::ccr_map_t'($past(HOST_ACC.wdata[1:0], 2));
endproperty
a_mode: assert property (p_mode) else $error("mapping mode wrong");
property p_clear;
    CARD_RESET [*2] |-> MAP_MODE == ccr_pkg::MAP_MEMORY && !LEVEL_IRQ && !EIGHT_BIT_IO;
endproperty
a_clear: assert property (p_clear) else $error("fields kept in soft reset");
property p_io8;
    take && HOST_ACC.addr == 11'h202 && !CARD_RESET
    |=> ##1 EIGHT_BIT_IO == $past(HOST_ACC.wdata[5], 2);
endproperty
a_io8: assert property (p_io8) else $error("eight bit flag wrong");
property p_pin; (MAP_MODE == ccr_pkg::MAP_MEMORY) [*2] |-> STATUS_CHANGE_PIN_N; endproperty
a_pin: assert property (p_pin) else $error("status pin low in memory mode");
property p_sleep;
    take && HOST_ACC.addr == 11'h202 && HOST_ACC.wdata[2] && !CORE_SLEEP
    |-> ##[1:12] CORE_SLEEP;
endproperty
a_sleep: assert property (p_sleep) else $error("sleep not reached");
property p_pinrep;
    !RDATA_OE_N && $past(HOST_ACC.addr) == 11'h204 |-> (RDATA & 8'hDD) == 8'h0C;
endproperty
a_pinrep: assert property (p_pinrep) else $error("pin register fixed bits");
property p_copy;
    !RDATA_OE_N && $past(HOST_ACC.addr) == 11'h206 |-> (RDATA & 8'hEF) == 8'h00;
endproperty
a_copy: assert property (p_copy) else $error("copy register fixed bits");
endmodule

//--- sim/ccr_host.sv
`timescale 1ns/1ns
module ccr_host (
    // Clock
    input wire logic CORE_CLK,
    // Card read data
    input wire logic [7:0] RDATA,
    input wire logic RDATA_OE_N,
    // Attribute strobes
    output ccr_pkg::ccr_acc_t HOST_ACC
);
initial HOST_ACC = '{1'b1, 1'b1, 1'b1, 1'b1, 11'h7FF, 8'hFF};
// Released bus shows inverted values, never a stale copy
task automatic idle();
    HOST_ACC = '{1'b1, 1'b1, 1'b1, 1'b1, ~HOST_ACC.addr, ~HOST_ACC.wdata};
endtask
task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge CORE_CLK);
    HOST_ACC = '{1'b0, 1'b0, 1'b1, 1'b0, a, d};
    @(negedge CORE_CLK);
    idle();
endtask
task automatic rd(input logic [10:0] a, output logic [7:0] d, output logic oe_n);
    @(negedge CORE_CLK);
    HOST_ACC = '{1'b0, 1'b0, 1'b0, 1'b1, a, ~a[7:0]};
    repeat (2) @(negedge CORE_CLK);
    d = RDATA;
    oe_n = RDATA_OE_N;
    idle();
endtask
endmodule

//--- sim/tb_card_configuration_registers.sv
`timescale 1ns/1ns
module tb_card_configuration_registers;
logic core_clk, rst, true_ide, core_ready, core_irq, irq_disable, core_idle, core_cmd;
logic [7:0] rdata, w, d;
logic rdata_oe_n, status_change_pin_n, card_reset, level_irq, eight_bit_io, core_sleep, o;
ccr_pkg::ccr_acc_t host_acc;
ccr_pkg::ccr_map_t map_mode;
int bad_count = 0;
int comparisons = 0;
int unsigned seed_v;
ccr_regs i_dut (.CORE_CLK(core_clk), .RST(rst), .HOST_ACC(host_acc), .TRUE_IDE(true_ide),
    .CORE_READY(core_ready), .CORE_IRQ(core_irq), .IRQ_DISABLE(irq_disable),
    .CORE_IDLE(core_idle), .CORE_CMD(core_cmd), .RDATA(rdata), .RDATA_OE_N(rdata_oe_n),
    .STATUS_CHANGE_PIN_N(status_change_pin_n), .CARD_RESET(card_reset), .LEVEL_IRQ(level_irq),
    .MAP_MODE(map_mode), .EIGHT_BIT_IO(eight_bit_io), .CORE_SLEEP(core_sleep));
ccr_host i_host (.CORE_CLK(core_clk), .RDATA(rdata), .RDATA_OE_N(rdata_oe_n),
    .HOST_ACC(host_acc));
always #25 core_clk = ~core_clk;
////////////////////////////////////////////////////////////
function automatic logic [7:0] sts_exp(input logic [7:0] v, input logic chg, input logic irq);
    return {chg, v[6:5], 2'b00, v[2], irq, 1'b0};
endfunction
task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
        bad_count++;
        $display("ERROR %s expected %h seen %h", what, exp, got);
    end
endtask
task automatic rdc(input logic [10:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    logic oe;
    i_host.rd(a, v, oe);
    chk("read_oe_n", 8'h00, {7'h00, oe});
    chk("read_data", e, v & m);
endtask
task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
initial begin
    #2000000;
    bad_count++;
    tally_and_finish();
end
////////////////////////////////////////////////////////////
initial begin
    {core_clk, rst, true_ide, core_irq, irq_disable, core_idle, core_cmd} = 7'h20;
    core_ready = 1'b1;
    seed_v = $urandom(32'h3A75);
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    rdc(11'h200, 8'hFF, 8'h00);
    rdc(11'h202, 8'hFF, 8'h00);
    rdc(11'h204, 8'hFF, 8'h0E);
    rdc(11'h206, 8'hFF, 8'h00);
    for (int i = 0; i < 16; i++) begin
        w = 8'($urandom);
        i_host.wr(11'h206, w);
        i_host.wr(11'h200, {1'b0, w[6], 4'h0, 2'(i)});
        i_host.wr(11'h202, w & 8'hFB);
        i_host.wr(11'h204, w & 8'hDD);
        rdc(11'h206, 8'hFF, w & 8'h10);
        rdc(11'h200, 8'hFF, {1'b0, w[6], 4'h0, 2'(i)});
        rdc(11'h202, 8'hFF, sts_exp(w & 8'hFB, 1'b0, 1'b0));
        rdc(11'h204, 8'hFF, 8'h0E);
        chk("map_mode", 8'(i % 4), {6'h00, map_mode});
        chk("level_irq", {7'h00, w[6]}, {7'h00, level_irq});
        chk("eight_bit_io", {7'h00, w[5]}, {7'h00, eight_bit_io});
    end
    core_irq = 1'b1;
    rdc(11'h202, 8'h02, 8'h02);
    irq_disable = 1'b1;
    rdc(11'h202, 8'h02, 8'h00);
    {core_irq, irq_disable} = 2'b00;
    i_host.wr(11'h202, 8'h40);
    core_ready = 1'b0;
    rdc(11'h204, 8'h22, 8'h20);
    rdc(11'h202, 8'h80, 8'h80);
    chk("status_pin", 8'h00, {7'h00, status_change_pin_n});
    i_host.wr(11'h202, 8'h00);
    @(negedge core_clk);
    chk("status_pin", 8'h01, {7'h00, status_change_pin_n});
    // Clear the latch and mask it, then the ready edge must not set it
    i_host.wr(11'h204, 8'h02);
    core_ready = 1'b1;
    rdc(11'h204, 8'h22, 8'h02);
    i_host.wr(11'h204, 8'h00);
    i_host.wr(11'h202, 8'h04);
    rdc(11'h204, 8'h02, 8'h00);
    repeat (12) @(negedge core_clk);
    chk("core_sleep", 8'h01, {7'h00, core_sleep});
    rdc(11'h204, 8'h02, 8'h02);
    i_host.wr(11'h202, 8'h00);
    repeat (12) @(negedge core_clk);
    chk("core_sleep", 8'h00, {7'h00, core_sleep});
    core_idle = 1'b1;
    repeat (12) @(negedge core_clk);
    chk("auto_sleep", 8'h01, {7'h00, core_sleep});
    {core_idle, core_cmd} = 2'b01;
    repeat (12) @(negedge core_clk);
    chk("auto_wake", 8'h00, {7'h00, core_sleep});
    core_cmd = 1'b0;
    true_ide = 1'b1;
    i_host.wr(11'h200, 8'h02);
    i_host.rd(11'h200, d, o);
    chk("ide_oe_n", 8'h01, {7'h00, o});
    true_ide = 1'b0;
    chk("map_mode", 8'h03, {6'h00, map_mode});
    i_host.rd(11'h208, d, o);
    chk("unmapped_oe_n", 8'h01, {7'h00, o});
    i_host.wr(11'h202, 8'h60);
    i_host.wr(11'h200, 8'hC3);
    // The reset output follows the stored bit one edge later
    @(negedge core_clk);
    chk("card_reset", 8'h01, {7'h00, card_reset});
    rdc(11'h200, 8'hFF, 8'h80);
    rdc(11'h202, 8'h64, 8'h00);
    i_host.wr(11'h200, 8'h00);
    @(negedge core_clk);
    chk("card_reset", 8'h00, {7'h00, card_reset});
    chk("map_mode", 8'h00, {6'h00, map_mode});
    // Hard reset in mid-run must clear a configured mode
    i_host.wr(11'h200, 8'h43);
    @(negedge core_clk);
    chk("map_mode", 8'h03, {6'h00, map_mode});
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    chk("rst_map_mode", 8'h00, {6'h00, map_mode});
    chk("rst_level_irq", 8'h00, {7'h00, level_irq});
    rdc(11'h200, 8'hFF, 8'h00);
    tally_and_finish();
end
endmodule
bind ccr_regs ccr_regs_sva i_sva (.CORE_CLK(CORE_CLK), .RST(RST), .HOST_ACC(HOST_ACC),
    .TRUE_IDE(TRUE_IDE), .RDATA(RDATA), .RDATA_OE_N(RDATA_OE_N),
    .STATUS_CHANGE_PIN_N(STATUS_CHANGE_PIN_N), .CARD_RESET(CARD_RESET),
    .LEVEL_IRQ(LEVEL_IRQ), .MAP_MODE(MAP_MODE), .EIGHT_BIT_IO(EIGHT_BIT_IO),
    .CORE_SLEEP(CORE_SLEEP));
